// ---- byte_exec_pkg.sv ----
package byte_exec_pkg;

    // Opcode patterns, compared against the top bits of a program word
    localparam logic [9:0] OP_LOAD_PTR = 10'h3B8; // 1110 1110 00
    localparam logic [5:0] OP_COPY = 6'h14; // 0101 00
    localparam logic [5:0] OP_ROTATE = 6'h10; // 0100 00
    localparam logic [6:0] OP_FILL = 7'h34; // 0110 100
    localparam logic [7:0] FILL_VALUE = 8'hFF;

    // Access bank split and indexed-literal-offset limit
    localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam int INDEX_POINTER = 2;

    // Register byte offsets on the bus
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_BANK = 6'h04;
    localparam logic [5:0] OFS_WREG = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0C;
    localparam logic [5:0] OFS_POINTER0 = 6'h10;
    localparam logic [5:0] POINTER_STRIDE = 6'h04;

    // Field positions and reset values
    localparam int CTRL_EXT_BIT = 0;
    localparam int STATUS_Z_BIT = 0;
    localparam int STATUS_N_BIT = 1;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [7:0] WREG_RESET = 8'h00;

    // Avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LIT2 = 4'h2,
        ST_RDWAIT = 4'h4,
        ST_EXEC = 4'h8
    } exec_state_e;

    // Operand of a byte-oriented instruction carried into execution
    typedef struct packed {
        logic rotate;
        logic dest;
        logic [11:0] addr;
    } byte_op_s;

endpackage

// ---- byte_exec_props.sv ----
module byte_exec_props (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR_WORD,
    input wire logic INSTR_READY,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    input wire logic [7:0] WREG,
    input wire logic STATUS_N,
    input wire logic STATUS_Z,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lit2;
    logic [7:0] rd_q;
    wire take = INSTR_VALID && INSTR_READY && !lit2;
    wire [5:0] op = INSTR_WORD[15:10];
    wire fill = take && INSTR_WORD[15:9] == byte_exec_pkg::OP_FILL;
    wire rot = take && op == byte_exec_pkg::OP_ROTATE;
    wire cpy = take && op == byte_exec_pkg::OP_COPY;
    // Second load word carries no opcode, so keep it out of decode
    always_ff @(posedge CORE_CLK) begin
        if (RST)
            lit2 <= 1'b0;
        else if (INSTR_VALID && INSTR_READY)
            lit2 <= !lit2 && INSTR_WORD[15:6] == byte_exec_pkg::OP_LOAD_PTR;
    end
    // Read data as it stood one cycle back
    always_ff @(posedge CORE_CLK) begin
        rd_q <= MEM_RDATA;
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence s_stall;
        MEM_RD && !INSTR_READY ##1 !MEM_RD && !INSTR_READY;
    endsequence
    sequence s_back;
        ##2 MEM_WR;
    endsequence
    chk_bus_one_wait:
        assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
            |=> !AVS_WAITREQUEST) else $error("bus wait not one cycle");
    chk_idle_wait_high:
        assert property (!AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST)
            else $error("waitrequest low while idle");
    chk_read_pulse:
        assert property (MEM_RD |=> !MEM_RD) else $error("read pulse long");
    chk_read_stall:
        assert property (rot || cpy |=> s_stall) else $error("no read stall");
    chk_rot_writeback:
        assert property (rot && INSTR_WORD[9] |=> s_back ##0
            MEM_WDATA == {rd_q[0], rd_q[7:1]}) else $error("bad rotate");
    chk_copy_to_wreg:
        assert property (cpy && !INSTR_WORD[9] |=> ##2 !MEM_WR && WREG == rd_q
            && STATUS_N == rd_q[7] && STATUS_Z == (rd_q == 8'h00))
            else $error("bad copy to working register");
    chk_fill_once:
        assert property (fill |=> MEM_WR
            && MEM_WDATA == byte_exec_pkg::FILL_VALUE) else $error("bad fill");
    chk_fill_flags:
        assert property (fill |=> $stable(STATUS_N) && $stable(STATUS_Z))
            else $error("fill changed flags");
endmodule // byte_exec_props

// ---- byte_file_instruction_exec.sv ----
// Operation
// - The pointer-load instruction puts a 12-bit literal into the pointer pair named by its 2-bit selector, of which three pairs exist.
// - The pointer-load takes two words and two cycles, writing the literal's top bits to the high byte first and its low eight bits to the low byte second.
// - The pointer-load's first word is recognised by top bits 1110 1110 00, then two selector bits, then the literal's top bits.
// - For copy and rotate a destination bit of 0 sends the result to the working register and 1 writes it back to the file register.
// - A bank bit of 0 takes the operand from the access bank ignoring the bank select register, and 1 lets that register pick the bank.
// - With bank bit 0 and the extended set enabled, file addresses up to 95 use indexed literal offset addressing.
// - The rotate instruction, top bits 0100 00da, rotates the register right by one, bit 0 wrapping to bit 7, with no carry.
// - The fill instruction, top bits 0110 100a, writes FFh to the register in one instruction and leaves the flags unchanged.
// - For fill a bank bit of 1 lets the bank select register pick the bank, and 0 selects the access bank.
module byte_file_instruction_exec #(
    parameter int POINTER_PAIRS = 3
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    // Instruction words from fetch
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR_WORD,
    output logic INSTR_READY,
    // Data memory, read data valid the cycle after MEM_RD
    output logic [11:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    // Core state seen by the rest of the core
    output logic [7:0] WREG,
    output logic STATUS_N,
    output logic STATUS_Z,
    // Avalon-MM slave
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic [1:0] AVS_RESPONSE,
    output logic AVS_WAITREQUEST
);

    // Pair 2 is the index base, so fewer pairs cannot serve
    if (POINTER_PAIRS < 3 || POINTER_PAIRS > 4) begin : g_check
        $error("POINTER_PAIRS must be 3 or 4");
    end

    byte_exec_pkg::exec_state_e state;
    byte_exec_pkg::byte_op_s op;
    logic [3:0] ptr_high [POINTER_PAIRS];
    logic [7:0] ptr_low [POINTER_PAIRS];
    logic [1:0] ptr_sel;
    logic ext_enable;
    logic [3:0] bank_select;
    logic bus_done;
    logic [7:0] result;
    logic [11:0] eff_addr;
    logic is_load, is_copy, is_rotate, is_fill;
    logic take_word;
    logic bus_req;
    logic bus_wr_now;

    assign take_word = INSTR_VALID && INSTR_READY;
    assign bus_req = AVS_READ || AVS_WRITE;
    assign bus_wr_now = AVS_WRITE && bus_done && AVS_BYTEENABLE[0];

    // Opcode recognition on the top bits of the word
    assign is_load = INSTR_WORD[15:6] == byte_exec_pkg::OP_LOAD_PTR;
    assign is_copy = INSTR_WORD[15:10] == byte_exec_pkg::OP_COPY;
    assign is_rotate = INSTR_WORD[15:10] == byte_exec_pkg::OP_ROTATE;
    assign is_fill = INSTR_WORD[15:9] == byte_exec_pkg::OP_FILL;

    // Accept words only in ST_IDLE and ST_LIT2, not while a copy or rotate reads and executes
    assign INSTR_READY = state == byte_exec_pkg::ST_IDLE
        || state == byte_exec_pkg::ST_LIT2;

    // Effective address from bank bit, bank select and extended mode
    always_comb begin
        logic [7:0] f;
        f = INSTR_WORD[7:0];
        if (INSTR_WORD[8]) begin
            eff_addr = {bank_select, f};
        end else if (ext_enable && f <= byte_exec_pkg::ACCESS_LOW_LIMIT) begin
            eff_addr = {ptr_high[byte_exec_pkg::INDEX_POINTER],
                ptr_low[byte_exec_pkg::INDEX_POINTER]}
                + {4'h0, f};
        end else if (f <= byte_exec_pkg::ACCESS_LOW_LIMIT) begin
            eff_addr = {4'h0, f};
        end else begin
            eff_addr = {byte_exec_pkg::ACCESS_HIGH_BANK, f};
        end
    end

    // Copy passes data through, rotate wraps bit 0 into bit 7
    assign result = op.rotate ? {MEM_RDATA[0], MEM_RDATA[7:1]}
        : MEM_RDATA;

    // Sequencer; second word of a pointer load always follows the first
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state <= byte_exec_pkg::ST_IDLE;
        end else begin
            case (state)
                byte_exec_pkg::ST_IDLE: begin
                    if (take_word && is_load) begin
                        state <= byte_exec_pkg::ST_LIT2;
                    end else if (take_word && (is_copy || is_rotate)) begin
                        state <= byte_exec_pkg::ST_RDWAIT;
                    end
                end
                byte_exec_pkg::ST_LIT2: begin
                    if (take_word) begin
                        state <= byte_exec_pkg::ST_IDLE;
                    end
                end
                byte_exec_pkg::ST_RDWAIT: begin
                    state <= byte_exec_pkg::ST_EXEC;
                end
                byte_exec_pkg::ST_EXEC: begin
                    state <= byte_exec_pkg::ST_IDLE;
                end
                default: begin
                    state <= byte_exec_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Operand capture for the read-modify-write instructions
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            op <= '0;
            ptr_sel <= 2'h0;
        end else if (take_word && state == byte_exec_pkg::ST_IDLE) begin
            op.rotate <= is_rotate;
            op.dest <= INSTR_WORD[9];
            op.addr <= eff_addr;
            ptr_sel <= INSTR_WORD[5:4];
        end
    end

    // Pointer pairs: high nibble on word one, low byte on word two
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            for (int i = 0; i < POINTER_PAIRS; i++) begin
                ptr_high[i] <= 4'h0;
                ptr_low[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < POINTER_PAIRS; i++) begin
                // Selector 3 names no pair and is dropped
                if (take_word && state == byte_exec_pkg::ST_IDLE && is_load
                    && INSTR_WORD[5:4] == i[1:0] && i < 3) begin
                    ptr_high[i] <= INSTR_WORD[3:0];
                end
                if (take_word && state == byte_exec_pkg::ST_LIT2
                    && ptr_sel == i[1:0] && i < 3) begin
                    ptr_low[i] <= INSTR_WORD[7:0];
                end
            end
        end
    end

    // Memory port; all data outputs registered
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            MEM_ADDR <= 12'h000;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            MEM_WDATA <= 8'h00;
        end else begin
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            if (take_word && state == byte_exec_pkg::ST_IDLE
                && (is_copy || is_rotate)) begin
                MEM_ADDR <= eff_addr;
                MEM_RD <= 1'b1;
            end else if (take_word && state == byte_exec_pkg::ST_IDLE
                && is_fill) begin
                MEM_ADDR <= eff_addr;
                MEM_WR <= 1'b1;
                MEM_WDATA <= byte_exec_pkg::FILL_VALUE;
            end else if (state == byte_exec_pkg::ST_EXEC && op.dest) begin
                MEM_ADDR <= op.addr;
                MEM_WR <= 1'b1;
                MEM_WDATA <= result;
            end
        end
    end

    // Working register; instruction result beats a bus write
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            WREG <= byte_exec_pkg::WREG_RESET;
        end else if (state == byte_exec_pkg::ST_EXEC && !op.dest) begin
            WREG <= result;
        end else if (bus_wr_now && AVS_ADDRESS == byte_exec_pkg::OFS_WREG) begin
            WREG <= AVS_WRITEDATA[7:0];
        end
    end

    // Flags change only on copy and rotate; fill leaves them alone
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            STATUS_N <= 1'b0;
            STATUS_Z <= 1'b0;
        end else if (state == byte_exec_pkg::ST_EXEC) begin
            STATUS_N <= result[7];
            STATUS_Z <= result == 8'h00;
        end
    end

    // Software control registers
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ext_enable <= byte_exec_pkg::CTRL_RESET;
            bank_select <= byte_exec_pkg::BANK_RESET;
        end else if (bus_wr_now) begin
            if (AVS_ADDRESS == byte_exec_pkg::OFS_CTRL) begin
                ext_enable <= AVS_WRITEDATA[byte_exec_pkg::CTRL_EXT_BIT];
            end else if (AVS_ADDRESS == byte_exec_pkg::OFS_BANK) begin
                bank_select <= AVS_WRITEDATA[3:0];
            end
        end
    end

    // One wait cycle per access keeps read data a registered output
    assign AVS_WAITREQUEST = !bus_done;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            bus_done <= 1'b0;
        end else begin
            bus_done <= bus_req && !bus_done;
        end
    end

    // Read data and response, sampled on the first edge of a request, one edge before it is accepted
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            AVS_READDATA <= 32'h0000_0000;
            AVS_RESPONSE <= byte_exec_pkg::RESP_OKAY;
        end else if (bus_req && !bus_done) begin
            AVS_READDATA <= 32'h0000_0000;
            AVS_RESPONSE <= byte_exec_pkg::RESP_OKAY;
            if (AVS_ADDRESS == byte_exec_pkg::OFS_CTRL) begin
                AVS_READDATA[byte_exec_pkg::CTRL_EXT_BIT] <= ext_enable;
            end else if (AVS_ADDRESS == byte_exec_pkg::OFS_BANK) begin
                AVS_READDATA[3:0] <= bank_select;
            end else if (AVS_ADDRESS == byte_exec_pkg::OFS_WREG) begin
                AVS_READDATA[7:0] <= WREG;
            end else if (AVS_ADDRESS == byte_exec_pkg::OFS_STATUS) begin
                AVS_READDATA[byte_exec_pkg::STATUS_N_BIT] <= STATUS_N;
                AVS_READDATA[byte_exec_pkg::STATUS_Z_BIT] <= STATUS_Z;
            end else if (AVS_ADDRESS >= byte_exec_pkg::OFS_POINTER0
                && AVS_ADDRESS < byte_exec_pkg::OFS_POINTER0 + 6'h0C
                && AVS_ADDRESS[1:0] == 2'h0) begin
                for (int i = 0; i < 3; i++) begin
                    if (AVS_ADDRESS == byte_exec_pkg::OFS_POINTER0
                        + 6'(i) * byte_exec_pkg::POINTER_STRIDE) begin
                        AVS_READDATA[11:0] <= {ptr_high[i], ptr_low[i]};
                    end
                end
            end else begin
                AVS_RESPONSE <= byte_exec_pkg::RESP_SLVERR;
            end
        end
    end

endmodule // byte_file_instruction_exec

// ---- byte_file_instruction_exec_tb.sv ----
module byte_file_instruction_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK = 1'b0, RST = 1'b1, INSTR_VALID = 1'b0, AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0, INSTR_READY, MEM_RD, MEM_WR, STATUS_N, STATUS_Z;
    logic AVS_WAITREQUEST, ext = 1'b0, a, d, rot;
    logic [15:0] INSTR_WORD = 16'h0000;
    logic [7:0] MEM_RDATA = 8'h00, MEM_WDATA, WREG, f, m, res;
    logic [11:0] MEM_ADDR, ad;
    logic [5:0] AVS_ADDRESS = 6'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, seed = 32'h9420;
    logic [3:0] AVS_BYTEENABLE = 4'hF, bank = 4'h0;
    logic [1:0] AVS_RESPONSE;
    logic [11:0] kv [0:2];
    logic [19:0] exq [$];
    int fail_count = 0, samples_checked = 0;
    byte_file_instruction_exec dut (.*);
    initial begin
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Memory content is a fixed function of the address
    function automatic logic [7:0] mv(input logic [11:0] x);
        return x[7:0] ^ {x[11:8], x[11:8]} ^ 8'h3C;
    endfunction
    function automatic logic [11:0] ea(input logic ba, input logic [7:0] fa);
        if (ba)
            return {bank, fa};
        if (ext && fa <= 8'h5F)
            return kv[2] + {4'h0, fa};
        return fa <= 8'h5F ? {4'h0, fa} : {4'hF, fa};
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic report_and_stop;
        fail_count += exq.size();
        $display("Checked %0d, failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hold the request until waitrequest is seen low at an edge;
    // only the watchdog ends a wait, so a stuck slave fails the run
    task automatic bus(input logic w, input logic [5:0] x, input logic [31:0] v,
                       output logic [31:0] q, output logic [1:0] r);
        @(posedge CORE_CLK);
        AVS_ADDRESS <= x;
        AVS_WRITEDATA <= v;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge CORE_CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        r = AVS_RESPONSE;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] x, input logic [31:0] e,
                      input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, x, 32'h0, q, r);
        chk(e, q);
        chk({30'h0, er}, {30'h0, r});
    endtask
    task automatic wr(input logic [5:0] x, input logic [31:0] v);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, x, v, q, r);
    endtask
    // Offer a word and keep it until it is taken; valid stays up after
    task automatic ins(input logic [15:0] w);
        INSTR_VALID <= 1'b1;
        INSTR_WORD <= w;
        do begin
            @(posedge CORE_CLK);
        end while (INSTR_READY !== 1'b1);
    endtask
    task automatic idle;
        INSTR_VALID <= 1'b0;
        INSTR_WORD <= seed[15:0];
        repeat (4) @(posedge CORE_CLK);
    endtask
    // Synchronous memory; unread data lines toggle so stale bytes show
    always @(posedge CORE_CLK) begin
        MEM_RDATA <= MEM_RD ? mv(MEM_ADDR) : ~MEM_RDATA;
        if (!RST && MEM_WR === 1'b1)
            chk(exq.size() > 0 ? exq.pop_front() : 20'hFFFFF,
                {MEM_ADDR, MEM_WDATA});
    end
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'b0;
        rd(byte_exec_pkg::OFS_CTRL, 32'h0, byte_exec_pkg::RESP_OKAY);
        rd(6'h3C, 32'h0, byte_exec_pkg::RESP_SLVERR);
        // Back-to-back two-word loads, then one to the missing pair
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            if (i < 3)
                kv[i] = seed[11:0];
            ins({byte_exec_pkg::OP_LOAD_PTR, 2'(i), seed[11:8]});
            ins({8'hF0, seed[7:0]});
        end
        idle();
        for (int i = 0; i < 3; i++)
            rd(6'(6'h10 + 6'(4 * i)), {20'h0, kv[i]}, 2'h0);
        for (int e = 0; e < 2; e++) begin
            ext = e[0];
            bank = 4'h3 + 4'(e);
            wr(byte_exec_pkg::OFS_CTRL, 32'(e));
            wr(byte_exec_pkg::OFS_BANK, {28'h0, bank});
            for (int j = 0; j < 12; j++) begin
                seed = xs(seed);
                f = j == 0 ? 8'h3C : seed[7:0];
                a = j == 0 ? 1'b0 : seed[8];
                d = seed[9];
                ad = ea(a, f);
                if (j % 3 == 1) begin
                    exq.push_back({ad, byte_exec_pkg::FILL_VALUE});
                    ins({byte_exec_pkg::OP_FILL, a, f});
                end else begin
                    rot = j % 3 == 2;
                    m = mv(ad);
                    res = rot ? {m[0], m[7:1]} : m;
                    if (d)
                        exq.push_back({ad, res});
                    ins({rot ? byte_exec_pkg::OP_ROTATE : byte_exec_pkg::OP_COPY,
                         d, a, f});
                    idle();
                    if (!d)
                        chk({24'h0, res}, {24'h0, WREG});
                    chk({res[7], res == 8'h00}, {STATUS_N, STATUS_Z});
                end
            end
            idle();
        end
        report_and_stop();
    end
endmodule // byte_file_instruction_exec_tb
bind byte_file_instruction_exec byte_exec_props chk (.*);
